// ==== sps_map.svh ====
// Register offsets, field positions and timing counts of the profile/stall register bank
// Assumes a 10 MHz system clock and SPI frames of 16 bits
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
`define SPS_ADDR_REG1      3'h1
`define SPS_ADDR_REG2      3'h2
`define SPS_ADDR_REG3      3'h3
`define SPS_ADDR_REG4      3'h4
`define SPS_ADDR_REG5      3'h5
`define SPS_ADDR_REG6      3'h6
`define SPS_REG_RESET      13'h0000
`define SPS_FRAME_BITS     5'h10
`define SPS_BIT_OVKEEP     7
`define SPS_BIT_PWMDIS     5
`define SPS_BIT_OPEN_A     5
`define SPS_BIT_OPEN_B     6
`define SPS_BIT_REFERR     7
`define SPS_BIT_STALL      8
`define SPS_BIT_FREQ       9
`define SPS_BIT_FILT       10
`define SPS_BIT_STPIN      11
`define SPS_BIT_CLR        12
`define SPS_CLK_HZ         10000000
`define SPS_FILT_SHORT_NS  1500
`define SPS_FILT_LONG_NS   2500
`define SPS_FILT_SHORT_CYC ((`SPS_FILT_SHORT_NS * (`SPS_CLK_HZ / 1000000) + 999) / 1000)
`define SPS_FILT_LONG_CYC  ((`SPS_FILT_LONG_NS * (`SPS_CLK_HZ / 1000000) + 999) / 1000)
`define SPS_PWM20_HZ       20000
`define SPS_PWM30_HZ       30000
`define SPS_PWM20_CYC      (`SPS_CLK_HZ / `SPS_PWM20_HZ)
`define SPS_PWM30_CYC      (`SPS_CLK_HZ / `SPS_PWM30_HZ)
`endif

// ==== sps_pkg.sv ====
// Types shared by the profile/stall register bank
// Assumes sps_map.svh supplies the numbers
package sps_pkg;
    typedef logic [12:0] sps_reg_t;
    typedef struct packed {
        logic       ov_keep;
        logic       pwm_pin_disable;
        logic [7:0] stall_threshold;
        logic       pwm_freq_select;
        logic       glitch_filter_select;
        logic       stall_to_pwm_pin;
    } sps_cfg_t;
    typedef enum logic [1:0] {
        SPS_IDLE  = 2'b00,
        SPS_FRAME = 2'b01,
        SPS_DONE  = 2'b10
    } sps_state_t;
endpackage

// ==== sps_regs.sv ====
// Registers 2 to 6 of a two-bridge stepper driver, written over a 16-bit SPI frame
// Assumes SPI pins asynchronous to clk_sys; SPI clock well below clk_sys/4
// Notes on behaviour
// [RL1] Profile entry copied into bridge DAC field
// [RL2] Master writes zero to test bits
// [RL3] Overvoltage, keep bit zero: outputs off, flag
// [RL4] Overvoltage, keep bit one: outputs kept, flag
// [RL5] Reg3 bits 7:6 are threshold low bits
// [RL6] Threshold assembled from regs 3, 4, 5
// [RL7] PWM pin disable bit tristates pin
// [RL8] Reg6 bits 6:5 report open load
// [RL9] Reg6 bit 7 reports reference current error
// [RL10] Reg6 bit 8 is stall flag
// [RL11] Reg6 bit 9 selects PWM frequency
// [RL12] Reg6 bit 10 selects glitch filter time
// [RL13] Reg6 bit 11 mirrors stall on pin
// [RL14] Reg6 bit 12 write clears status flags
// [RL15] First three bits select the register
// [RL16] Write only on exactly sixteen edges
// [RL17] Stall when rise sum below threshold
// [RL18] Reset zero; writes keep status bits
`timescale 1ns/1ps
`include "sps_map.svh"
module sps_regs #(
    parameter int PWM20_CYC = `SPS_PWM20_CYC,
    parameter int PWM30_CYC = `SPS_PWM30_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        chip_select_n,
    input  wire logic        spi_clk,
    input  wire logic        serial_data_in,
    input  wire logic        supply_overvoltage_event,
    input  wire logic        open_load_a,
    input  wire logic        open_load_b,
    input  wire logic        refcurrent_fault,
    input  wire logic        pwm_bridge_a,
    input  wire logic [7:0]  rise_time_sum,
    input  wire logic        quadrant_done,
    input  wire logic        profile_load,
    input  wire logic [3:0]  profile_index,
    input  wire logic        profile_to_b,
    output logic      [4:0]  dac_bridge_a,
    output logic      [4:0]  dac_bridge_b,
    output logic             bridges_off,
    output logic             supply_overvoltage_flag,
    output logic             pwm_pin_out,
    output logic             pwm_pin_oe,
    output logic             pwm_freq_select,
    output logic             glitch_filter_select,
    output logic      [7:0]  pwm_period_cycles,
    output logic      [7:0]  glitch_filter_cycles,
    output logic      [7:0]  stall_threshold,
    output logic             stall_flag
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic       csn_d;
    logic       sck_d;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            // Idle pin levels, so no false edge after reset
            sync1 <= 3'h4;
            sync2 <= 3'h4;
            csn_d <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            sync1 <= {chip_select_n, spi_clk, serial_data_in};
            sync2 <= sync1;
            csn_d <= sync2[2];
            sck_d <= sync2[1];
        end
    end
    logic sck_rise;
    logic csn_rise;
    assign sck_rise = sync2[1] & ~sck_d;
    assign csn_rise = sync2[2] & ~csn_d;

    // ****************************************************************
    // Frame shifter and edge counter
    // ****************************************************************
    logic [15:0]          shreg;
    logic [4:0]           bitcnt;
    logic                 over;
    sps_pkg::sps_state_t  state;
    logic [15:0]          next_shreg;
    logic [4:0]           next_bitcnt;
    logic                 next_over;
    sps_pkg::sps_state_t  next_state;
    logic                 wr_strobe;
    always_comb begin
        next_shreg  = shreg;
        next_bitcnt = bitcnt;
        next_over   = over;
        next_state  = state;
        wr_strobe   = 1'b0;
        case (state)
            sps_pkg::SPS_IDLE: begin
                if (!sync2[2]) begin
                    next_bitcnt = 5'h00;
                    next_over   = 1'b0;
                    next_state  = sps_pkg::SPS_FRAME;
                end
            end
            sps_pkg::SPS_FRAME: begin
                if (sck_rise && !sync2[2]) begin
                    next_shreg = {shreg[14:0], sync2[0]};
                    if (bitcnt == `SPS_FRAME_BITS) begin
                        next_over = 1'b1;
                    end else begin
                        next_bitcnt = bitcnt + 5'h01;
                    end
                end
                if (csn_rise) begin
                    next_state = sps_pkg::SPS_DONE;
                end
            end
            sps_pkg::SPS_DONE: begin
                wr_strobe  = (bitcnt == `SPS_FRAME_BITS) && !over; // [RL16]
                next_state = sps_pkg::SPS_IDLE;
            end
            default: next_state = sps_pkg::SPS_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shreg  <= 16'h0000;
            bitcnt <= 5'h00;
            over   <= 1'b0;
            state  <= sps_pkg::SPS_IDLE;
        end else begin
            shreg  <= next_shreg;
            bitcnt <= next_bitcnt;
            over   <= next_over;
            state  <= next_state;
        end
    end

    // ****************************************************************
    // Register bank
    // ****************************************************************
    logic [2:0]  wr_addr;
    logic [12:0] wr_data;
    assign wr_addr = shreg[15:13]; // [RL15]
    assign wr_data = shreg[12:0];
    sps_pkg::sps_reg_t regs      [2:6];
    sps_pkg::sps_reg_t next_regs [2:6];
    logic              next_ovflag;
    logic              ovflag;
    always_comb begin
        for (int i = 2; i <= 6; i++) begin
            next_regs[i] = regs[i];
        end
        next_ovflag = ovflag | supply_overvoltage_event; // [RL3] [RL4]
        if (wr_strobe) begin
            for (int i = 2; i <= 5; i++) begin
                if (wr_addr == 3'(i)) begin
                    next_regs[i] = wr_data;
                end
            end
            if (wr_addr == `SPS_ADDR_REG6) begin
                // Status bits 8..5 stay; clear bit stored for readback
                next_regs[6] = {wr_data[12:9], regs[6][8:5], wr_data[4:0]}; // [RL18]
                if (wr_data[`SPS_BIT_CLR]) begin
                    next_regs[6][8:5] = 4'h0; // [RL14]
                end
            end
        end
        // Hardware sets win over clear
        if (open_load_a) next_regs[6][`SPS_BIT_OPEN_A] = 1'b1; // [RL8]
        if (open_load_b) next_regs[6][`SPS_BIT_OPEN_B] = 1'b1; // [RL8]
        if (refcurrent_fault) next_regs[6][`SPS_BIT_REFERR] = 1'b1; // [RL9]
        if (quadrant_done && (rise_time_sum < stall_threshold)) begin
            next_regs[6][`SPS_BIT_STALL] = 1'b1; // [RL10] [RL17]
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 2; i <= 6; i++) begin
                regs[i] <= `SPS_REG_RESET; // [RL18]
            end
            ovflag <= 1'b0;
        end else begin
            for (int i = 2; i <= 6; i++) begin
                regs[i] <= next_regs[i];
            end
            ovflag <= next_ovflag;
        end
    end

    // ****************************************************************
    // Derived configuration
    // ****************************************************************
    sps_pkg::sps_cfg_t cfg;
    always_comb begin
        cfg.ov_keep              = regs[2][`SPS_BIT_OVKEEP];
        cfg.pwm_pin_disable      = regs[3][`SPS_BIT_PWMDIS];
        cfg.stall_threshold      = {regs[5][7:5], regs[4][7:5], regs[3][7:6]}; // [RL5] [RL6]
        cfg.pwm_freq_select      = regs[6][`SPS_BIT_FREQ];
        cfg.glitch_filter_select = regs[6][`SPS_BIT_FILT];
        cfg.stall_to_pwm_pin     = regs[6][`SPS_BIT_STPIN];
    end

    // Profile entry lookup, index 0..8
    logic [4:0] prof;
    always_comb begin
        case (profile_index)
            4'h0:    prof = regs[2][4:0];
            4'h1:    prof = regs[2][12:8];
            4'h2:    prof = regs[3][4:0];
            4'h3:    prof = regs[3][12:8];
            4'h4:    prof = regs[4][4:0];
            4'h5:    prof = regs[4][12:8];
            4'h6:    prof = regs[5][4:0];
            4'h7:    prof = regs[5][12:8];
            4'h8:    prof = regs[6][4:0];
            default: prof = 5'h00;
        endcase
    end

    // ****************************************************************
    // Output registers
    // ****************************************************************
    logic [4:0] next_dac_a;
    logic [4:0] next_dac_b;
    logic       next_pin;
    always_comb begin
        next_dac_a = dac_bridge_a;
        next_dac_b = dac_bridge_b;
        if (profile_load && !profile_to_b) next_dac_a = prof; // [RL1]
        if (profile_load && profile_to_b)  next_dac_b = prof; // [RL1]
        next_pin = cfg.stall_to_pwm_pin ? regs[6][`SPS_BIT_STALL] : pwm_bridge_a; // [RL13]
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dac_bridge_a            <= 5'h00;
            dac_bridge_b            <= 5'h00;
            bridges_off             <= 1'b0;
            supply_overvoltage_flag <= 1'b0;
            pwm_pin_out             <= 1'b0;
            pwm_pin_oe              <= 1'b0;
            pwm_freq_select         <= 1'b0;
            glitch_filter_select    <= 1'b0;
            pwm_period_cycles       <= 8'h00;
            glitch_filter_cycles    <= 8'h00;
            stall_threshold         <= 8'h00;
            stall_flag              <= 1'b0;
        end else begin
            dac_bridge_a            <= next_dac_a;
            dac_bridge_b            <= next_dac_b;
            bridges_off             <= next_ovflag && !cfg.ov_keep; // [RL3] [RL4]
            supply_overvoltage_flag <= next_ovflag;
            pwm_pin_out             <= next_pin;
            pwm_pin_oe              <= !cfg.pwm_pin_disable; // [RL7]
            pwm_freq_select         <= cfg.pwm_freq_select;
            glitch_filter_select    <= cfg.glitch_filter_select;
            pwm_period_cycles       <= cfg.pwm_freq_select ? 8'(PWM20_CYC)
                                                           : 8'(PWM30_CYC); // [RL11]
            glitch_filter_cycles    <= cfg.glitch_filter_select ? 8'(`SPS_FILT_LONG_CYC)
                                                                : 8'(`SPS_FILT_SHORT_CYC); // [RL12]
            stall_threshold         <= cfg.stall_threshold;
            stall_flag              <= regs[6][`SPS_BIT_STALL];
        end
    end
endmodule

// ==== sps_regs_sva.sv ====
// Checker for the profile/stall register bank outputs
// Assumes it is bound to sps_regs and sees only its ports
`timescale 1ns/1ps
module sps_regs_sva #(
    parameter int PWM20_CYC = 500,
    parameter int PWM30_CYC = 333
) (
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic       chip_select_n,
    input wire logic       supply_overvoltage_event,
    input wire logic       supply_overvoltage_flag,
    input wire logic       bridges_off,
    input wire logic       pwm_bridge_a,
    input wire logic       stall_flag,
    input wire logic       pwm_pin_out,
    input wire logic       pwm_pin_oe,
    input wire logic       quadrant_done,
    input wire logic [7:0] rise_time_sum,
    input wire logic [7:0] stall_threshold,
    input wire logic       glitch_filter_select,
    input wire logic [7:0] glitch_filter_cycles,
    input wire logic       pwm_freq_select,
    input wire logic [7:0] pwm_period_cycles,
    input wire logic [4:0] dac_bridge_a,
    input wire logic       profile_load,
    input wire logic       profile_to_b
);
    // *****
    // Cycles since chip select was last low
    // *****
    logic [3:0] since_cs;
    logic [3:0] next_since_cs;
    always_comb begin
        next_since_cs = (since_cs == 4'hF) ? since_cs : since_cs + 4'h1;
        if (!chip_select_n) begin
            next_since_cs = 4'h0;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            since_cs <= 4'h0;
        end else begin
            since_cs <= next_since_cs;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    AST_OV_SET: assert property (supply_overvoltage_event |-> ##[1:2] supply_overvoltage_flag)
        else $error("overvoltage flag not set");
    AST_OV_HOLD: assert property (supply_overvoltage_flag |=> supply_overvoltage_flag)
        else $error("overvoltage flag dropped");
    AST_OFF_FLAG: assert property (bridges_off |-> supply_overvoltage_flag)
        else $error("bridges off without flag");
    AST_PIN_LOW: assert property ((!pwm_bridge_a && !stall_flag)[*3] |-> !pwm_pin_out)
        else $error("pwm pin high with both sources low");
    AST_STALL_SET: assert property (quadrant_done && rise_time_sum < stall_threshold
        |-> ##[1:3] stall_flag)
        else $error("stall flag not set");
    AST_STALL_CLR: assert property ($fell(stall_flag) |-> since_cs < 4'hA)
        else $error("stall flag cleared without a frame");
    AST_FILT: assert property ($stable(glitch_filter_select)[*3] |->
        glitch_filter_cycles == (glitch_filter_select ? 8'h19 : 8'h0F))
        else $error("filter cycles wrong");
    AST_PERIOD: assert property ($stable(pwm_freq_select)[*3] |->
        pwm_period_cycles == (pwm_freq_select ? 8'(PWM20_CYC) : 8'(PWM30_CYC)))
        else $error("pwm period wrong");
    AST_OE_CHG: assert property ($changed(pwm_pin_oe) |-> since_cs < 4'hA)
        else $error("pin enable changed without a frame");
    AST_DAC_A: assert property ($changed(dac_bridge_a) |->
        $past(profile_load) && !$past(profile_to_b))
        else $error("bridge A DAC changed without a load");
endmodule

// ==== sps_spi_master.sv ====
// SPI master model sending 16-bit write frames
// Assumes clk_sys of the bench; spi clock is 9 system cycles
`timescale 1ns/1ps
module sps_spi_master (
    input  wire logic clk_sys,
    output logic      chip_select_n,
    output logic      spi_clk,
    output logic      serial_data_in
);
    initial begin
        chip_select_n  = 1'b1;
        spi_clk        = 1'b0;
        serial_data_in = 1'b0;
    end
    // *****
    // Frame of n clocks, MSB first
    // *****
    task automatic send(input logic [15:0] word, input int n);
        @(negedge clk_sys) chip_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys) serial_data_in = word[(15 - i) & 15];
            repeat (4) @(negedge clk_sys);
            spi_clk = 1'b1;
            repeat (4) @(negedge clk_sys);
            spi_clk = 1'b0;
        end
        repeat (2) @(negedge clk_sys);
        chip_select_n  = 1'b1;
        serial_data_in = 1'b0;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

// ==== sps_regs_tb.sv ====
// Testbench of the profile/stall register bank
// Assumes sps_spi_master as the far side and sps_regs_sva bound
`timescale 1ns/1ps
`include "sps_map.svh"
module sps_regs_tb;
    logic       clk_sys = 1'b0;
    logic       arst_n, chip_select_n, spi_clk, serial_data_in;
    logic       supply_overvoltage_event, open_load_a, open_load_b, refcurrent_fault;
    logic       pwm_bridge_a, quadrant_done, profile_load, profile_to_b, bridges_off;
    logic       supply_overvoltage_flag, pwm_pin_out, pwm_pin_oe, stall_flag;
    logic       pwm_freq_select, glitch_filter_select;
    logic [7:0] rise_time_sum, pwm_period_cycles, glitch_filter_cycles, stall_threshold;
    logic [4:0] dac_bridge_a, dac_bridge_b;
    logic [3:0] profile_index;
    logic [4:0] prof [0:8] = '{5'h11, 5'h1E, 5'h0A, 5'h13, 5'h05, 5'h04, 5'h07, 5'h06, 5'h08};
    int         n_mismatch = 0;
    int         total_checks = 0;
    sps_regs sps_regs_i (.*);
    sps_spi_master sps_spi_master_i (.*);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // *****
    // Tasks
    // *****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] addr, input logic [12:0] data);
        sps_spi_master_i.send({addr, data}, 16);
    endtask
    task automatic rst;
        arst_n = 1'b0;
        repeat (12) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic pulse(ref logic sig);
        @(negedge clk_sys) sig = 1'b1;
        @(negedge clk_sys) sig = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic tally_and_finish;
        $display("Mismatches %0d, checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // *****
    // Scenarios
    // *****
    initial begin
        {supply_overvoltage_event, open_load_a, open_load_b, refcurrent_fault} = 4'h0;
        {pwm_bridge_a, quadrant_done, profile_load, profile_to_b} = 4'h0;
        rise_time_sum = 8'h00;
        profile_index = 4'h0;
        rst;
        chk({5'h0, stall_flag, bridges_off, pwm_pin_oe}, 8'h01);
        chk(pwm_period_cycles, 8'(`SPS_PWM30_CYC));
        chk(glitch_filter_cycles, 8'(`SPS_FILT_SHORT_CYC));
        wr(`SPS_ADDR_REG2, 13'h1E11);
        wr(`SPS_ADDR_REG3, {5'h13, 2'b10, 1'b0, 5'h0A});
        wr(`SPS_ADDR_REG4, {5'h04, 3'b011, 5'h05});
        wr(`SPS_ADDR_REG5, {5'h06, 3'b101, 5'h07});
        wr(`SPS_ADDR_REG6, 13'h0008);
        chk(stall_threshold, {3'b101, 3'b011, 2'b10});
        for (int i = 0; i < 9; i++) begin
            @(negedge clk_sys) {profile_index, profile_to_b} = {4'(i), 1'(i)};
            pulse(profile_load);
            chk(i[0] ? dac_bridge_b : dac_bridge_a, prof[i]);
        end
        sps_spi_master_i.send({`SPS_ADDR_REG3, 13'h1FFF}, 15);
        sps_spi_master_i.send({`SPS_ADDR_REG3, 13'h1FFF}, 17);
        wr(3'h7, 13'h1FFF);
        chk({pwm_pin_oe, stall_threshold[1:0]}, 8'h06);
        pulse(open_load_a);
        pulse(refcurrent_fault);
        pwm_bridge_a = 1'b1;
        pulse(open_load_b);
        chk({5'h0, sps_regs_i.regs[6][7:5]}, 8'h07);
        chk(pwm_pin_out, 8'h01);
        pwm_bridge_a = 1'b0;
        wr(`SPS_ADDR_REG3, {5'h13, 2'b10, 1'b1, 5'h0A});
        chk(pwm_pin_oe, 8'h00);
        rise_time_sum = 8'hAE;
        pulse(quadrant_done);
        chk(stall_flag, 8'h00);
        rise_time_sum = 8'hAD;
        pulse(quadrant_done);
        chk(stall_flag, 8'h01);
        wr(`SPS_ADDR_REG6, 13'h0FE8);
        chk({pwm_freq_select, glitch_filter_select, stall_flag}, 8'h07);
        chk({5'h0, sps_regs_i.regs[6][7:5]}, 8'h07);
        chk(pwm_period_cycles, 8'(`SPS_PWM20_CYC));
        chk(glitch_filter_cycles, 8'(`SPS_FILT_LONG_CYC));
        chk(pwm_pin_out, 8'h01);
        wr(`SPS_ADDR_REG6, 13'h1808);
        chk({stall_flag, pwm_pin_out}, 8'h00);
        chk({5'h0, sps_regs_i.regs[6][7:5]}, 8'h00);
        pulse(supply_overvoltage_event);
        chk({supply_overvoltage_flag, bridges_off}, 8'h03);
        rst;
        wr(`SPS_ADDR_REG2, 13'h1E91);
        pulse(supply_overvoltage_event);
        chk({supply_overvoltage_flag, bridges_off}, 8'h02);
        chk(stall_threshold, 8'h00);
        tally_and_finish;
    end
endmodule
bind sps_regs sps_regs_sva #(.PWM20_CYC(PWM20_CYC), .PWM30_CYC(PWM30_CYC)) sps_regs_sva_i (.*);
